// [cond_branch_defines.svh]
/*
 * Constants of the conditional branch evaluator: instruction field positions,
 * primary and extended opcodes, branch-options codes, register map and reset values.
 * Assumes nothing of its surroundings; included by its bare name.
 */
`ifndef COND_BRANCH_DEFINES_SVH
`define COND_BRANCH_DEFINES_SVH

// ============================================================
// Instruction fields
// ============================================================
`define CB_OPCD_HI 31
`define CB_OPCD_LO 26
`define CB_BOF_HI 25
`define CB_BOF_LO 21
`define CB_BI_HI 20
`define CB_BI_LO 16
`define CB_BD_HI 15
`define CB_BD_LO 2
`define CB_BD_SIGN 15
`define CB_AA_BIT 1
`define CB_LK_BIT 0
`define CB_XO_HI 10
`define CB_XO_LO 1
`define CB_HINT_BIT 0

// ============================================================
// Opcodes
// ============================================================
`define CB_OP_REL 6'h10
`define CB_OP_XL 6'h13
`define CB_XO_TO_LINK 10'h010
`define CB_XO_TO_COUNT 10'h210

// ============================================================
// Branch-options codes, hint bit masked off
// ============================================================
`define CB_BOF_IF_SET 5'h0C
`define CB_BOF_IF_CLEAR 5'h04
`define CB_BOF_ALWAYS 5'h14

// ============================================================
// Register map
// ============================================================
`define CB_ADDR_CTRL 4'h0
`define CB_ADDR_STAT 4'h4
`define CB_ADDR_COND 4'h8
`define CB_ADDR_CNT 4'hC
`define CB_CTRL_RST 32'h0000_0001
`define CB_COND_RST 32'h0000_0000
`define CB_RESP_OKAY 2'h0
`define CB_RESP_SLVERR 2'h2

`endif

// [cond_branch_pkg.sv]
/*
 * Types of the conditional branch evaluator.
 * Assumes cond_branch_defines.svh for the numbers it uses elsewhere.
 */
package cond_branch_pkg;

    // Kind of target of a decoded conditional branch.
    typedef enum logic [1:0] {
        TGT_NONE = 2'b00,
        TGT_DISP = 2'b01,
        TGT_LINK = 2'b10,
        TGT_COUNT = 2'b11
    } target_kind_t;

    // States of the bus slave.
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_WRESP = 2'b01,
        BUS_RRESP = 2'b10
    } bus_state_t;

endpackage

// [cond_branch_eval_and_static_predict.sv]
/*
 * Decode-stage evaluator of conditional branches with static prediction.
 * Takes one instruction per cycle from fetch, reports prediction and redirect
 * one cycle later. Registers are reached over AXI4-Lite on the same clock.
 * Assumes the condition register is written by software through the bus.
 */
`timescale 1ns/100ps
`include "cond_branch_defines.svh"

module cond_branch_eval_and_static_predict (
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic i_instr_valid,
    input wire logic [31:0] i_instr,
    input wire logic [31:0] i_instr_addr,
    input wire logic [31:0] i_return_link_reg,
    input wire logic [31:0] i_loop_count_reg,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic o_br_valid,
    output logic o_br_cond_taken,
    output logic o_br_predict_taken,
    output logic o_br_redirect,
    output logic o_br_link_update,
    output logic [31:0] o_br_target,
    output logic [31:0] o_br_link_value
);

    // ============================================================
    // State
    // ============================================================
    // All state lives in one packed record: the bus handshake flags, the
    // software registers and the decode results sit side by side, so that
    // one clocked process updates every flip-flop of the block.
    typedef struct packed {
        cond_branch_pkg::bus_state_t bus;
        logic aw_got;
        logic w_got;
        logic [3:0] waddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic arready;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [31:0] ctrl;
        logic [31:0] cond;
        logic [15:0] cnt_branch;
        logic [15:0] cnt_redirect;
        logic [1:0] last_kind;
        logic br_valid;
        logic cond_taken;
        logic pred_taken;
        logic redirect;
        logic link_update;
        logic [31:0] target;
        logic [31:0] link_value;
    } state_t;

    state_t cur_ff;
    state_t nxt_ff;

    // Anything that is not one of the three forms yields TGT_NONE and is refused.
    // Classifies an instruction word as a conditional branch form.
    function automatic cond_branch_pkg::target_kind_t kind_of(input logic [31:0] ins);
        logic [5:0] op;
        logic [9:0] xo;
        op = ins[`CB_OPCD_HI:`CB_OPCD_LO];
        xo = ins[`CB_XO_HI:`CB_XO_LO];
        if (op == `CB_OP_REL) begin
            kind_of = cond_branch_pkg::TGT_DISP;
        end else if (op == `CB_OP_XL && xo == `CB_XO_TO_LINK) begin
            kind_of = cond_branch_pkg::TGT_LINK;
        end else if (op == `CB_OP_XL && xo == `CB_XO_TO_COUNT) begin
            kind_of = cond_branch_pkg::TGT_COUNT;
        end else begin
            kind_of = cond_branch_pkg::TGT_NONE;
        end
    endfunction

    // Merges write data into a register under byte strobes.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                          input logic [3:0] strb);
        merge = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                merge[8*i +: 8] = dat[8*i +: 8];
            end
        end
    endfunction

    // ============================================================
    // Next-state logic
    // ============================================================
    always_comb begin
        logic [4:0] bof;
        logic [4:0] bi;
        logic hint;
        logic sel_bit;
        logic neg_disp;
        logic [31:0] disp;
        cond_branch_pkg::target_kind_t kind;
        nxt_ff = cur_ff;
        bof = i_instr[`CB_BOF_HI:`CB_BOF_LO];
        bi = i_instr[`CB_BI_HI:`CB_BI_LO];
        hint = bof[`CB_HINT_BIT];
        kind = kind_of(i_instr);
        neg_disp = i_instr[`CB_BD_SIGN];
        disp = {{16{i_instr[`CB_BD_SIGN]}}, i_instr[`CB_BD_HI:`CB_BD_LO], 2'b00};
        // Bit 0 of a field is less-than, 1 greater-than, 2 equal, 3 overflow or unordered.
        sel_bit = cur_ff.cond[5'd31 - bi];

        // A word is taken only while the enable bit is set; a refused word
        // clears the valid, redirect and link-update flags and leaves every other held result untouched.
        // Valid, redirect and link-update flags; held only one cycle.
        nxt_ff.br_valid = 1'b0;
        nxt_ff.redirect = 1'b0;
        nxt_ff.link_update = 1'b0;
        if (i_instr_valid && cur_ff.ctrl[0] && kind != cond_branch_pkg::TGT_NONE) begin
            nxt_ff.br_valid = 1'b1;
            nxt_ff.last_kind = kind;
            // Condition: set-form takes on bit set, clear-form on bit clear.
            case (bof & 5'h1E)
                `CB_BOF_IF_SET: nxt_ff.cond_taken = sel_bit;
                `CB_BOF_IF_CLEAR: nxt_ff.cond_taken = ~sel_bit;
                `CB_BOF_ALWAYS: nxt_ff.cond_taken = 1'b1;
                default: nxt_ff.cond_taken = 1'b0;
            endcase
            // A negative displacement flips the sense of the hint for the
            // displacement forms; register targets follow the hint directly.
            // Static prediction; the always-taken form ignores the hint.
            if ((bof & 5'h1E) == `CB_BOF_ALWAYS) begin
                nxt_ff.pred_taken = 1'b1;
            end else if (kind == cond_branch_pkg::TGT_DISP) begin
                nxt_ff.pred_taken = neg_disp ^ hint;
            end else begin
                nxt_ff.pred_taken = hint;
            end
            nxt_ff.redirect = (nxt_ff.cond_taken != nxt_ff.pred_taken);
            nxt_ff.link_update = i_instr[`CB_LK_BIT];
            nxt_ff.link_value = i_instr_addr + 32'h0000_0004;
            case (kind)
                cond_branch_pkg::TGT_DISP: begin
                    nxt_ff.target = i_instr[`CB_AA_BIT] ? disp : i_instr_addr + disp;
                end
                cond_branch_pkg::TGT_LINK: nxt_ff.target = {i_return_link_reg[31:2], 2'b00};
                default: nxt_ff.target = {i_loop_count_reg[31:2], 2'b00};
            endcase
            // Counters wrap silently; software reads them as one word.
            nxt_ff.cnt_branch = cur_ff.cnt_branch + 16'h0001;
            if (nxt_ff.redirect) begin
                nxt_ff.cnt_redirect = cur_ff.cnt_redirect + 16'h0001;
            end
        end

        // A read waits while either write channel is offered, so a write that
        // arrives alongside a read is always served first.
        // Bus write channel: address and data in either order.
        nxt_ff.awready = 1'b0;
        nxt_ff.wready = 1'b0;
        nxt_ff.arready = 1'b0;
        case (cur_ff.bus)
            cond_branch_pkg::BUS_IDLE: begin
                if (s_axi_awvalid && !cur_ff.aw_got && !cur_ff.awready) begin
                    nxt_ff.awready = 1'b1;
                end
                if (s_axi_wvalid && !cur_ff.w_got && !cur_ff.wready) begin
                    nxt_ff.wready = 1'b1;
                end
                if (cur_ff.awready && s_axi_awvalid) begin
                    nxt_ff.aw_got = 1'b1;
                    nxt_ff.waddr = s_axi_awaddr[3:0];
                end
                if (cur_ff.wready && s_axi_wvalid) begin
                    nxt_ff.w_got = 1'b1;
                    nxt_ff.wdata = s_axi_wdata;
                    nxt_ff.wstrb = s_axi_wstrb;
                end
                if (cur_ff.aw_got && cur_ff.w_got) begin
                    nxt_ff.aw_got = 1'b0;
                    nxt_ff.w_got = 1'b0;
                    nxt_ff.bvalid = 1'b1;
                    nxt_ff.bresp = `CB_RESP_OKAY;
                    nxt_ff.bus = cond_branch_pkg::BUS_WRESP;
                    case (cur_ff.waddr)
                        `CB_ADDR_CTRL: nxt_ff.ctrl = merge(cur_ff.ctrl, cur_ff.wdata,
                                                           cur_ff.wstrb) & 32'h0000_0001;
                        `CB_ADDR_COND: nxt_ff.cond = merge(cur_ff.cond, cur_ff.wdata,
                                                           cur_ff.wstrb);
                        `CB_ADDR_STAT, `CB_ADDR_CNT: nxt_ff.bresp = `CB_RESP_OKAY;
                        default: nxt_ff.bresp = `CB_RESP_SLVERR;
                    endcase
                end else if (!cur_ff.aw_got && !cur_ff.w_got && s_axi_arvalid
                             && !cur_ff.awready && !cur_ff.wready && !s_axi_awvalid
                             && !s_axi_wvalid) begin
                    nxt_ff.arready = 1'b1;
                    nxt_ff.bus = cond_branch_pkg::BUS_RRESP;
                end
            end
            cond_branch_pkg::BUS_WRESP: begin
                if (s_axi_bready) begin
                    nxt_ff.bvalid = 1'b0;
                    nxt_ff.bus = cond_branch_pkg::BUS_IDLE;
                end
            end
            cond_branch_pkg::BUS_RRESP: begin
                if (cur_ff.arready) begin
                    nxt_ff.rvalid = 1'b1;
                    nxt_ff.rresp = `CB_RESP_OKAY;
                    case (s_axi_araddr[3:0])
                        `CB_ADDR_CTRL: nxt_ff.rdata = cur_ff.ctrl;
                        `CB_ADDR_STAT: nxt_ff.rdata = {26'h0, cur_ff.last_kind,
                                                       cur_ff.redirect, cur_ff.pred_taken,
                                                       cur_ff.cond_taken, cur_ff.br_valid};
                        `CB_ADDR_COND: nxt_ff.rdata = cur_ff.cond;
                        `CB_ADDR_CNT: nxt_ff.rdata = {cur_ff.cnt_redirect, cur_ff.cnt_branch};
                        default: begin
                            nxt_ff.rdata = 32'h0000_0000;
                            nxt_ff.rresp = `CB_RESP_SLVERR;
                        end
                    endcase
                end else if (cur_ff.rvalid && s_axi_rready) begin
                    nxt_ff.rvalid = 1'b0;
                    nxt_ff.bus = cond_branch_pkg::BUS_IDLE;
                end
            end
            default: nxt_ff.bus = cond_branch_pkg::BUS_IDLE;
        endcase
    end

    // ============================================================
    // State register
    // ============================================================
    // Synchronous reset; the enable bit comes up set so decoding starts at once.
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            cur_ff <= '0;
            cur_ff.ctrl <= `CB_CTRL_RST;
            cur_ff.cond <= `CB_COND_RST;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    // ============================================================
    // Outputs straight from the state register
    // ============================================================
    // Every port is a plain copy of a register field, so no logic sits
    // between the flip-flops and the pins.
    assign s_axi_awready = cur_ff.awready;
    assign s_axi_wready = cur_ff.wready;
    assign s_axi_bresp = cur_ff.bresp;
    assign s_axi_bvalid = cur_ff.bvalid;
    assign s_axi_arready = cur_ff.arready;
    assign s_axi_rdata = cur_ff.rdata;
    assign s_axi_rresp = cur_ff.rresp;
    assign s_axi_rvalid = cur_ff.rvalid;
    assign o_br_valid = cur_ff.br_valid;
    assign o_br_cond_taken = cur_ff.cond_taken;
    assign o_br_predict_taken = cur_ff.pred_taken;
    assign o_br_redirect = cur_ff.redirect;
    assign o_br_link_update = cur_ff.link_update;
    assign o_br_target = cur_ff.target;
    assign o_br_link_value = cur_ff.link_value;

endmodule

// [fetch_model.sv]
/*
 * Fetch-stage stand-in that offers instruction words to the branch evaluator.
 * Assumes the bench calls drive or idle just after a rising clock edge.
 */
`timescale 1ns/100ps

module fetch_model (
    input wire logic i_clk_sys,
    output logic o_instr_valid,
    output logic [31:0] o_instr,
    output logic [31:0] o_instr_addr,
    output logic [31:0] o_link,
    output logic [31:0] o_count
);
    // Low target bits are nonzero so that their clearing is visible.
    initial begin
        o_instr_valid = 1'b0;
        o_instr = 32'h0000_0000;
        o_instr_addr = 32'h0000_0000;
        o_link = 32'h0000_2A57;
        o_count = 32'h0000_4C1E;
    end

    // Offers one word with its address.
    task drive(input logic [31:0] w, input logic [31:0] a);
        o_instr_valid <= 1'b1;
        o_instr <= w;
        o_instr_addr <= a;
    endtask

    // Released lines show the inverse of their last value.
    task idle();
        o_instr_valid <= 1'b0;
        o_instr <= ~o_instr;
        o_instr_addr <= ~o_instr_addr;
    endtask
endmodule

// [br_monitor.sv]
/*
 * Checker of the branch evaluator's instruction path.
 * Assumes it is bound to the top module and sees only its ports.
 */
`timescale 1ns/100ps
`include "cond_branch_defines.svh"

module br_monitor (
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic i_instr_valid,
    input wire logic [31:0] i_instr,
    input wire logic [31:0] i_instr_addr,
    input wire logic o_br_valid,
    input wire logic o_br_cond_taken,
    input wire logic o_br_predict_taken,
    input wire logic o_br_redirect,
    input wire logic o_br_link_update,
    input wire logic [31:0] o_br_link_value
);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rstn);

    // ============================================================
    // Decode steps
    // ============================================================
    // A hinted word of each target kind followed by its result.
    sequence s_disp_dec;
        i_instr_valid && i_instr[31:26] == `CB_OP_REL && i_instr[25:22] != 4'hA ##1 o_br_valid;
    endsequence
    sequence s_reg_dec;
        i_instr_valid && i_instr[31:26] == `CB_OP_XL && i_instr[25:22] != 4'hA ##1 o_br_valid;
    endsequence

    property p_pred_disp;
        s_disp_dec |-> o_br_predict_taken == ($past(i_instr[15]) ^ $past(i_instr[21]));
    endproperty
    property p_pred_reg;
        s_reg_dec |-> o_br_predict_taken == $past(i_instr[21]);
    endproperty
    property p_valid_cause;
        o_br_valid |-> $past(i_instr_valid);
    endproperty
    property p_nonbranch;
        i_instr_valid && i_instr[31:26] != `CB_OP_REL && i_instr[31:26] != `CB_OP_XL
            |=> !o_br_valid;
    endproperty
    property p_redirect;
        o_br_valid |-> o_br_redirect == (o_br_cond_taken != o_br_predict_taken);
    endproperty
    property p_pulses;
        !o_br_valid |-> !o_br_redirect && !o_br_link_update;
    endproperty
    property p_link_upd;
        o_br_valid |-> o_br_link_update == $past(i_instr[0]);
    endproperty
    property p_link_val;
        o_br_valid |-> o_br_link_value == $past(i_instr_addr) + 32'h0000_0004;
    endproperty
    property p_hold;
        !o_br_valid && $past(i_rstn) |-> $stable(o_br_predict_taken) && $stable(o_br_cond_taken);
    endproperty

    a_pred_disp: assert property (p_pred_disp) else $error("bad displacement prediction");
    a_pred_reg: assert property (p_pred_reg) else $error("bad register prediction");
    a_valid_cause: assert property (p_valid_cause) else $error("result without word");
    a_nonbranch: assert property (p_nonbranch) else $error("non-branch decoded");
    a_redirect: assert property (p_redirect) else $error("bad redirect");
    a_pulses: assert property (p_pulses) else $error("pulse outside result");
    a_link_upd: assert property (p_link_upd) else $error("bad link update");
    a_link_val: assert property (p_link_val) else $error("bad link value");
    a_hold: assert property (p_hold) else $error("result changed while idle");
endmodule

bind cond_branch_eval_and_static_predict br_monitor u_mon (
    .i_clk_sys(i_clk_sys),
    .i_rstn(i_rstn),
    .i_instr_valid(i_instr_valid),
    .i_instr(i_instr),
    .i_instr_addr(i_instr_addr),
    .o_br_valid(o_br_valid),
    .o_br_cond_taken(o_br_cond_taken),
    .o_br_predict_taken(o_br_predict_taken),
    .o_br_redirect(o_br_redirect),
    .o_br_link_update(o_br_link_update),
    .o_br_link_value(o_br_link_value)
);

// [tb.sv]
/*
 * Self-checking bench of the branch evaluator.
 * Assumes the fetch_model partner and the register map of the defines header.
 */
`timescale 1ns/100ps
`include "cond_branch_defines.svh"

module tb;
    logic i_clk_sys = 1'b0;
    logic i_rstn = 1'b0;
    logic v, b_valid, b_cond, b_pred, b_redir, b_lk;
    logic [3:0] wstrb = 4'hF;
    logic [31:0] w_in, a_in, lr, ctr, b_tgt, b_lv, rdata, awaddr = '0, wdata = '0, araddr = '0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    int n_errors = 0;
    int n_tests = 0;

    // Clock at 200 MHz.
    always #2.5 i_clk_sys = ~i_clk_sys;

    fetch_model fm (.i_clk_sys(i_clk_sys), .o_instr_valid(v), .o_instr(w_in),
        .o_instr_addr(a_in), .o_link(lr), .o_count(ctr));

    cond_branch_eval_and_static_predict dut (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn),
        .i_instr_valid(v), .i_instr(w_in), .i_instr_addr(a_in), .i_return_link_reg(lr),
        .i_loop_count_reg(ctr), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .o_br_valid(b_valid), .o_br_cond_taken(b_cond),
        .o_br_predict_taken(b_pred), .o_br_redirect(b_redir), .o_br_link_update(b_lk),
        .o_br_target(b_tgt), .o_br_link_value(b_lv));

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Write one word; address and data are released as each is taken.
    task axi_wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge i_clk_sys);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge i_clk_sys);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        chk(bresp, `CB_RESP_OKAY);
    endtask

    task axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge i_clk_sys);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge i_clk_sys);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    function automatic logic [31:0] bc(logic [4:0] bo, bi, logic [13:0] bd, logic aa, lk);
        return {`CB_OP_REL, bo, bi, bd, aa, lk};
    endfunction

    function automatic logic [31:0] xl(logic [4:0] bo, bi, logic [9:0] xo, logic lk);
        return {`CB_OP_XL, bo, bi, 5'h00, xo, lk};
    endfunction

    task chk_br(input logic [31:0] w, a, input logic ec, ep, input logic [31:0] et);
        chk(b_valid, 1'b1);
        chk(b_cond, ec);
        chk(b_pred, ep);
        chk(b_redir, ec ^ ep);
        chk(b_lk, w[0]);
        chk(b_tgt, et);
        chk(b_lv, a + 32'h0000_0004);
    endtask

    // Register reset values, read-back and an unmapped address.
    task t_regs();
        logic [31:0] d;
        logic [1:0] r;
        axi_rd({28'h0, `CB_ADDR_CTRL}, d, r);
        chk(d, `CB_CTRL_RST);
        axi_rd({28'h0, `CB_ADDR_COND}, d, r);
        chk(d, `CB_COND_RST);
        axi_wr({28'h0, `CB_ADDR_COND}, 32'hA5A5_0F0F);
        axi_rd({28'h0, `CB_ADDR_COND}, d, r);
        chk(d, 32'hA5A5_0F0F);
        wstrb <= 4'h3;
        axi_wr({28'h0, `CB_ADDR_COND}, 32'hFFFF_FFFF);
        wstrb <= 4'hF;
        axi_rd({28'h0, `CB_ADDR_COND}, d, r);
        chk(d, 32'hA5A5_FFFF);
        axi_rd(32'h0000_0002, d, r);
        chk(r, `CB_RESP_SLVERR);
        chk(d, 32'h0000_0000);
        $display("done t_regs");
    endtask

    // Seven options and index pairs, all but the set-form on index 0, against a lone set bit and its inverse.
    task t_cond();
        logic [4:0] bo_t [7] = '{5'h0C, 5'h04, 5'h04, 5'h0C, 5'h04, 5'h0C, 5'h04};
        logic [4:0] bi_t [7] = '{5'h01, 5'h01, 5'h00, 5'h03, 5'h03, 5'h02, 5'h02};
        logic [31:0] cr;
        logic ec;
        logic [31:0] w;
        for (int k = 0; k < 7; k++) begin
            for (int p = 0; p < 2; p++) begin
                cr = 32'h8000_0000 >> bi_t[k];
                if (p == 1) cr = ~cr;
                ec = (bo_t[k] == 5'h0C) ? (p == 0) : (p == 1);
                axi_wr({28'h0, `CB_ADDR_COND}, cr);
                @(posedge i_clk_sys);
                w = bc(bo_t[k], bi_t[k], 14'h0004, 1'b0, 1'b0);
                fm.drive(w, 32'h0000_3000);
                @(posedge i_clk_sys);
                fm.idle();
                #1 chk_br(w, 32'h0000_3000, ec, 1'b0, 32'h0000_3010);
            end
        end
        $display("done t_cond");
    endtask

    // Two words back to back, the equal bit set so the condition holds.
    task pair(input logic [31:0] w1, t1, input logic p1, input logic [31:0] w2, t2,
            input logic p2);
        @(posedge i_clk_sys);
        fm.drive(w1, 32'h0000_1000);
        @(posedge i_clk_sys);
        fm.drive(w2, 32'h0000_2000);
        #1 chk_br(w1, 32'h0000_1000, 1'b1, p1, t1);
        @(posedge i_clk_sys);
        fm.idle();
        #1 chk_br(w2, 32'h0000_2000, 1'b1, p2, t2);
    endtask

    // Static prediction over every target kind and hint value.
    task t_pred();
        axi_wr({28'h0, `CB_ADDR_COND}, 32'h2000_0000);
        pair(bc(5'h0C, 5'h02, 14'h3FFC, 1'b0, 1'b1), 32'h0000_0FF0, 1'b1,
            bc(5'h0D, 5'h02, 14'h3FFC, 1'b0, 1'b0), 32'h0000_1FF0, 1'b0);
        pair(bc(5'h0D, 5'h02, 14'h0008, 1'b1, 1'b1), 32'h0000_0020, 1'b1,
            bc(5'h0C, 5'h02, 14'h0008, 1'b0, 1'b0), 32'h0000_2020, 1'b0);
        pair(xl(5'h0C, 5'h02, `CB_XO_TO_LINK, 1'b0), 32'h0000_2A54, 1'b0,
            xl(5'h0D, 5'h02, `CB_XO_TO_LINK, 1'b1), 32'h0000_2A54, 1'b1);
        pair(xl(5'h0C, 5'h02, `CB_XO_TO_COUNT, 1'b1), 32'h0000_4C1C, 1'b0,
            xl(5'h0D, 5'h02, `CB_XO_TO_COUNT, 1'b0), 32'h0000_4C1C, 1'b1);
        pair(bc(5'h14, 5'h00, 14'h0004, 1'b0, 1'b0), 32'h0000_1010, 1'b1,
            xl(5'h15, 5'h00, `CB_XO_TO_COUNT, 1'b1), 32'h0000_4C1C, 1'b1);
        $display("done t_pred");
    endtask

    // A non-branch word, then a branch while the block is disabled.
    task t_refuse();
        logic [31:0] d;
        logic [1:0] r;
        @(posedge i_clk_sys);
        fm.drive(32'h7C00_0000, 32'h0000_4000);
        @(posedge i_clk_sys);
        fm.idle();
        #1 chk(b_valid, 1'b0);
        axi_wr({28'h0, `CB_ADDR_CTRL}, 32'h0000_0000);
        @(posedge i_clk_sys);
        fm.drive(bc(5'h0C, 5'h02, 14'h0004, 1'b0, 1'b1), 32'h0000_4000);
        @(posedge i_clk_sys);
        fm.idle();
        #1 chk(b_valid, 1'b0);
        axi_wr({28'h0, `CB_ADDR_CTRL}, `CB_CTRL_RST);
        axi_rd({28'h0, `CB_ADDR_CNT}, d, r);
        chk(d, 32'h000B_0018);
        $display("done t_refuse");
    endtask

    // Main sequence.
    initial begin
        repeat (12) @(posedge i_clk_sys);
        i_rstn <= 1'b1;
        t_regs();
        t_cond();
        t_pred();
        t_refuse();
        tally_and_finish();
    end

    // Watchdog against a hung handshake.
    initial begin
        #100000;
        n_errors++;
        tally_and_finish();
    end
endmodule
